//--- core/bit_op_if.sv
`timescale 1ns/1ps
interface bit_op_if;
    logic [7:0] oldVal;
    logic [2:0] bitSel;
    logic       doSet;
    logic       doClr;
    logic [7:0] newVal;
    logic [7:0] wrMask;
    logic       bitVal;
    modport user (output oldVal, bitSel, doSet, doClr, input newVal, wrMask, bitVal);
    modport unit (input oldVal, bitSel, doSet, doClr, output newVal, wrMask, bitVal);
endinterface : bit_op_if

//--- core/bit_op_unit.sv
`timescale 1ns/1ps
module bit_op_unit (
    // link to the register bank
    bit_op_if.unit bus
);
    // single-bit mask, value and picked bit
    always_comb begin
        bus.wrMask = 8'h01 << bus.bitSel;
        bus.bitVal = bus.oldVal[bus.bitSel];
        if (bus.doSet) begin
            bus.newVal = bus.oldVal | bus.wrMask;
        end else if (bus.doClr) begin
            bus.newVal = bus.oldVal & ~bus.wrMask;
        end else begin
            bus.newVal = bus.oldVal;
        end
    end
endmodule : bit_op_unit

//--- core/scratch_reg_bank.sv
`timescale 1ns/1ps
// Contract
// - writing one to a status flag clears it; writing zero leaves it
// - single-bit set or clear changes only the addressed bit
// - bit operations only at addresses 0x00 through 0x1F
// - three independently addressable scratch registers
// - scratch registers hold the last written value, hardware never alters them
// - the one low scratch register (0x1E) supports set, clear and both skip tests
module scratch_reg_bank
    import scratch_regs_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // core access port
    input  wire logic              reqValid,
    input  wire op_t               reqOp,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [DATA_W-1:0] reqWdata,
    input  wire logic [2:0]        reqBit,
    // read data and test answer
    output logic [DATA_W-1:0]      rdData,
    output logic                   rdValid,
    output logic                   skipTaken,
    output logic                   skipValid,
    // hardware events setting status flags
    input  wire logic [DATA_W-1:0] flagEvents,
    output logic [DATA_W-1:0]      flagsOut
);

    // stored bytes and their next values
    logic [DATA_W-1:0] scratch_q [NUM_SCRATCH];
    logic [DATA_W-1:0] scratch_d [NUM_SCRATCH];
    // status flags and their next value
    logic [DATA_W-1:0] flags_q;
    logic [DATA_W-1:0] flags_d;
    // read answer
    logic [DATA_W-1:0] rdData_q;
    logic [DATA_W-1:0] rdData_d;
    logic              rdValid_q;
    logic              rdValid_d;
    // test answer
    logic              skipTaken_q;
    logic              skipTaken_d;
    logic              skipValid_q;
    logic              skipValid_d;
    // decoded request
    logic [DATA_W-1:0] selVal;
    logic [1:0]        selSlot;
    logic              flagHit;
    logic              hit;
    logic              bitAddrOk;
    logic              isBitOp;
    logic              isSkip;
    logic              doWrite;
    logic              doRead;

    // slot index meaning no scratch register
    localparam logic [1:0] NO_SLOT = 2'h3;

    bit_op_if bop ();

    bit_op_unit u_bit_op (
        .bus (bop.unit)
    );

    // map an address to a scratch slot index, NUM_SCRATCH when none
    function automatic logic [1:0] slotOf(input logic [ADDR_W-1:0] a);
        logic [1:0] s;
        s = 2'h3;
        if (a == ADDR_SCR0) s = 2'h0;
        if (a == ADDR_SCR1) s = 2'h1;
        if (a == ADDR_SCR2) s = 2'h2;
        return s;
    endfunction : slotOf

    // true for the two single-bit modify operations
    function automatic logic isModifyOp(input op_t o);
        return (o == set_single_bit_op) || (o == clear_single_bit_op);
    endfunction : isModifyOp

    // true for the two bit test operations
    function automatic logic isTestOp(input op_t o);
        return (o == skip_if_bit_one_op) || (o == skip_if_bit_zero_op);
    endfunction : isTestOp

    // outcome of a skip test on the picked bit
    function automatic logic testHolds(input op_t o, input logic b);
        logic r;
        r = 1'b0;
        if (o == skip_if_bit_one_op) r = b;
        if (o == skip_if_bit_zero_op) r = !b;
        return r;
    endfunction : testHolds

    // addressed register contents
    always_comb begin
        selSlot = slotOf(reqAddr);
        flagHit = (reqAddr == ADDR_FLAGS);
        selVal  = 8'h00;
        hit     = 1'b1;
        if (flagHit) begin
            selVal = flags_q;
        end else if (selSlot != NO_SLOT) begin
            selVal = scratch_q[selSlot];
        end else begin
            // unmapped addresses read as zero
            hit = 1'b0;
        end
    end

    // operation class, bit access only in the low range
    always_comb begin
        bitAddrOk = (reqAddr <= BIT_OP_TOP);
        isBitOp   = reqValid && bitAddrOk && isModifyOp(reqOp);
        isSkip    = reqValid && bitAddrOk && isTestOp(reqOp);
        doWrite   = reqValid && hit && (reqOp == OP_WRITE);
        doRead    = reqValid && (reqOp == OP_READ);
    end

    // feed the bit helper
    always_comb begin
        bop.oldVal = selVal;
        bop.bitSel = reqBit;
        bop.doSet  = (reqOp == set_single_bit_op);
        bop.doClr  = (reqOp == clear_single_bit_op);
    end

    // one storage byte per slot, software is its only writer
    for (genvar g = 0; g < NUM_SCRATCH; g++) begin : g_slot
        // next value: write, bit modify or hold
        always_comb begin
            scratch_d[g] = scratch_q[g];
            if (doWrite && selSlot == 2'(g)) begin
                scratch_d[g] = reqWdata;
            end else if (isBitOp && selSlot == 2'(g)) begin
                scratch_d[g] = bop.newVal;
            end
        end

        // storage byte, zero at reset
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                scratch_q[g] <= SCRATCH_RST;
            end else begin
                scratch_q[g] <= scratch_d[g];
            end
        end
    end : g_slot

    // status flags: events set, written ones clear, set wins
    always_comb begin
        flags_d = flags_q | flagEvents;
        if (doWrite && flagHit) begin
            // a written zero leaves its flag alone
            flags_d = (flags_q & ~reqWdata) | flagEvents;
        end else if (isBitOp && flagHit) begin
            // only the addressed bit is written; a one there clears it
            flags_d = (flags_q & ~(bop.wrMask & bop.newVal)) | flagEvents;
        end
    end

    // status flag register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // read answer, data held until the next read
    always_comb begin
        rdData_d  = rdData_q;
        rdValid_d = 1'b0;
        if (doRead) begin
            rdData_d  = selVal;
            rdValid_d = 1'b1;
        end
    end

    // read answer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q  <= 8'h00;
            rdValid_q <= 1'b0;
        end else begin
            rdData_q  <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    // skip answer, only for low addresses
    always_comb begin
        skipValid_d = 1'b0;
        skipTaken_d = 1'b0;
        if (isSkip) begin
            skipValid_d = 1'b1;
            skipTaken_d = hit && testHolds(reqOp, bop.bitVal);
        end
    end

    // skip answer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skipTaken_q <= 1'b0;
            skipValid_q <= 1'b0;
        end else begin
            skipTaken_q <= skipTaken_d;
            skipValid_q <= skipValid_d;
        end
    end

    // outputs straight from the registers
    assign rdData    = rdData_q;
    assign rdValid   = rdValid_q;
    assign skipTaken = skipTaken_q;
    assign skipValid = skipValid_q;
    assign flagsOut  = flags_q;

endmodule : scratch_reg_bank

//--- core/scratch_regs_pkg.sv
package scratch_regs_pkg;

    // register geometry and placement
    localparam int          DATA_W       = 8;
    localparam int          ADDR_W       = 6;
    localparam int          NUM_SCRATCH  = 3;
    localparam logic [7:0]  SCRATCH_RST  = 8'h00;
    localparam logic [5:0]  BIT_OP_TOP   = 6'h1F;
    localparam logic [5:0]  ADDR_SCR0    = 6'h1E;
    localparam logic [5:0]  ADDR_SCR1    = 6'h2A;
    localparam logic [5:0]  ADDR_SCR2    = 6'h2B;
    localparam logic [5:0]  ADDR_FLAGS   = 6'h1D;
    localparam logic [7:0]  FLAGS_RST    = 8'h00;

    // operation codes from the core
    typedef enum logic [2:0] {
        OP_NONE            = 3'h0,
        OP_WRITE           = 3'h1,
        OP_READ            = 3'h2,
        set_single_bit_op  = 3'h3,
        clear_single_bit_op = 3'h4,
        skip_if_bit_one_op = 3'h5,
        skip_if_bit_zero_op = 3'h6
    } op_t;

endpackage : scratch_regs_pkg

//--- tb/core_model.sv
`timescale 1ns/1ps
module core_model
    import scratch_regs_pkg::*;
(
    // clock in, request out
    input wire logic  clk,
    output logic      reqValid = 1'b0,
    output op_t       reqOp = OP_NONE,
    output logic [5:0] reqAddr = 6'h00,
    output logic [7:0] reqWdata = 8'h00,
    output logic [2:0] reqBit = 3'h0
);
    // one request, held for the taking edge
    task issue(input op_t o, input logic [5:0] a, input logic [7:0] d, input logic [2:0] b);
        @(posedge clk);
        reqValid <= 1'b1;
        reqOp <= o;
        reqAddr <= a;
        reqWdata <= d;
        reqBit <= b;
        @(posedge clk);
        reqValid <= 1'b0;
    endtask : issue
endmodule : core_model

//--- tb/scratch_reg_bank_checker.sv
`timescale 1ns/1ps
module scratch_reg_bank_checker
    import scratch_regs_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // request from the core
    input wire logic       reqValid,
    input wire op_t        reqOp,
    input wire logic [5:0] reqAddr,
    input wire logic [7:0] reqWdata,
    input wire logic [2:0] reqBit,
    // answers and flags
    input wire logic       rdValid,
    input wire logic [7:0] rdData,
    input wire logic       skipTaken,
    input wire logic       skipValid,
    input wire logic [7:0] flagEvents,
    input wire logic [7:0] flagsOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // request decodes
    wire rd = reqValid && reqOp == OP_READ;
    wire sk = reqValid && reqOp inside {skip_if_bit_one_op, skip_if_bit_zero_op};
    wire fw = reqValid && reqAddr == ADDR_FLAGS;
    flag_clear_a: assert property (fw && reqOp == OP_WRITE |=>
        flagsOut == ($past(flagsOut) & ~$past(reqWdata) | $past(flagEvents))) else $error("flag clear wrong");
    bit_only_a: assert property (fw && reqOp == set_single_bit_op |=>
        flagsOut == ($past(flagsOut) & ~(8'h01 << $past(reqBit)) | $past(flagEvents))) else $error("bit set wrong");
    bit_keep_a: assert property (fw && reqOp == clear_single_bit_op |=>
        flagsOut == ($past(flagsOut) | $past(flagEvents))) else $error("zero write cleared flag");
    taken_qualified_a: assert property (skipTaken |-> skipValid) else $error("skip taken without valid");
    high_refuse_a: assert property (sk && reqAddr > BIT_OP_TOP |=> !skipValid) else $error("high skip answered");
    low_skip_a: assert property (sk && reqAddr <= BIT_OP_TOP |=> skipValid) else $error("low skip lost");
    read_answer_a: assert property (rdValid == $past(rd)) else $error("read answer timing");
    data_hold_a: assert property (!rdValid |-> $stable(rdData)) else $error("read data moved");
    reset_zero_a: assert property ($rose(rst_n) |-> rdData == 8'h00 && flagsOut == 8'h00)
        else $error("not zero after reset");
endmodule : scratch_reg_bank_checker
bind scratch_reg_bank scratch_reg_bank_checker chk_u (.clk, .rst_n, .reqValid, .rdValid, .skipTaken,
    .skipValid, .reqOp, .reqAddr, .reqWdata, .rdData, .flagEvents, .flagsOut, .reqBit);

//--- tb/scratch_reg_bank_tb_top.sv
`timescale 1ns/1ps
module scratch_reg_bank_tb_top;
    import scratch_regs_pkg::*;
    typedef struct {op_t o; logic [5:0] a; logic [7:0] d; logic [2:0] b; logic [7:0] e;} row_t;
    localparam op_t WR = OP_WRITE, RD = OP_READ, ST = set_single_bit_op, CL = clear_single_bit_op;
    localparam op_t S1 = skip_if_bit_one_op, S0 = skip_if_bit_zero_op;
    logic       clk = 1'b0, rst_n = 1'b0, reqValid, rdValid, skipTaken, skipValid;
    op_t        reqOp;
    logic [5:0] reqAddr;
    logic [7:0] reqWdata, rdData, flagsOut, got, flagEvents = 8'h00;
    logic [2:0] reqBit;
    int         nMismatch = 0, checks = 0;
    // e is read data, {valid,taken} for skips, else flags
    row_t rows [21] = '{
        '{WR,6'h1E,8'hA5,3'h0,8'h0F}, '{RD,6'h1E,8'h00,3'h0,8'hA5},
        '{WR,6'h2A,8'h3C,3'h0,8'h0F}, '{WR,6'h2B,8'hC3,3'h0,8'h0F},
        '{RD,6'h2A,8'h00,3'h0,8'h3C}, '{RD,6'h2B,8'h00,3'h0,8'hC3},
        '{ST,6'h1E,8'h00,3'h1,8'h0F}, '{CL,6'h1E,8'h00,3'h7,8'h0F},
        '{RD,6'h1E,8'h00,3'h0,8'h27}, '{S1,6'h1E,8'h00,3'h0,8'h03},
        '{S0,6'h1E,8'h00,3'h3,8'h03}, '{S1,6'h1E,8'h00,3'h4,8'h02},
        '{ST,6'h2A,8'h00,3'h0,8'h0F}, '{RD,6'h2A,8'h00,3'h0,8'h3C},
        '{S1,6'h2A,8'h00,3'h2,8'h00},
        '{WR,6'h1D,8'h01,3'h0,8'h0E}, '{WR,6'h1D,8'h00,3'h0,8'h0E},
        '{ST,6'h1D,8'h00,3'h2,8'h0A}, '{CL,6'h1D,8'h00,3'h3,8'h0A},
        '{RD,6'h05,8'h00,3'h0,8'h00}, '{S0,6'h05,8'h00,3'h0,8'h02}};
    always #12.5 clk = ~clk;
    core_model core_u (.clk, .reqValid, .reqOp, .reqAddr, .reqWdata, .reqBit);
    scratch_reg_bank dut_u (.clk, .rst_n, .reqValid, .reqOp, .reqAddr, .reqWdata, .reqBit, .rdData,
        .rdValid, .skipTaken, .skipValid, .flagEvents, .flagsOut);
    // issue one row and compare its answer
    task run(input row_t r);
        string what;
        core_u.issue(r.o, r.a, r.d, r.b);
        #1;
        what = "flagsOut";
        if (r.o == RD) what = "rdData";
        if (r.o inside {S1, S0}) what = "skip";
        got = r.o == RD ? rdData : r.o inside {S1, S0} ? {6'h00, skipValid, skipTaken} : flagsOut;
        checks++;
        if (got !== r.e) begin
            nMismatch++;
            $display("MISMATCH %s exp %h seen %h", what, r.e, got);
        end
        if (r.o == RD) begin
            checks++;
            if (rdValid !== 1'b1) begin
                nMismatch++;
                $display("MISMATCH rdValid exp 1 seen %b", rdValid);
            end
        end
    endtask : run
    task conclude;
        $display("checks %0d mismatches %0d", checks, nMismatch);
        if (nMismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    // watchdog
    initial begin
        #50us;
        nMismatch++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        flagEvents <= 8'h0F;
        @(posedge clk);
        flagEvents <= 8'h00;
        foreach (rows[i]) run(rows[i]);
        // event and write-one clear in one cycle: the event wins
        @(posedge clk);
        flagEvents <= 8'h10;
        run('{WR,6'h1D,8'h12,3'h0,8'h18});
        @(posedge clk);
        flagEvents <= 8'h00;
        run('{WR,6'h1D,8'h10,3'h0,8'h08});
        // reset in mid-run clears scratch and flags
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        run('{RD,6'h1E,8'h00,3'h0,8'h00});
        run('{RD,6'h2A,8'h00,3'h0,8'h00});
        run('{WR,6'h2B,8'h00,3'h0,8'h00});
        conclude();
    end
endmodule : scratch_reg_bank_tb_top
